// *** rtl/eom_monitor.sv ***
// Eye opening monitor: scan engine, lock monitor and register readout
// Overview of operation
// - Count comparator disagreements per point over dwell
// - Full scan covers 64 by 64 points
// - Opening mode: phase sweep, then voltage sweep
// - Openings readable at horizontal_opening and vertical_opening
// - Lock monitor measures periodically, flags lost lock
// - Power-down bit resets high, wakes periodically
// - Range source bit low selects register range
// - Range code picks 100 to 400 mV span
// - Start bit in fast mode begins scan
// - Start bit clears after whole grid read
// - Burst reads: lower byte follows upper byte
// - Lower byte read frees the next point
// - Single mode: next point after both bytes
// - Dwell grows with register eye_dwell_time value
// - Rereading eye_count_upper resumes an interrupted burst
module eom_monitor (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  input wire logic sample_valid,
  input wire logic primary_bit,
  input wire logic offset_bit,
  input wire logic [1:0] cdr_range,
  output logic [5:0] phase_offset,
  output logic [5:0] volt_offset,
  output logic monitor_power,
  output logic [1:0] eom_range,
  output logic lock_lost
);
  import eom_pkg::*;

  typedef struct packed {
    logic [7:0] rng_pwr, ovr, dwell, rsrc, lockmon, thresh, chsel;
    logic [7:0] horizontal_opening, vertical_opening;
    logic fast, start, lm_run, lock_lost, pwr_o;
    logic [1:0] range_o;
    eom_scan_t st;
    logic [5:0] phase, volt, first, last;
    logic [17:0] acc;
    logic [15:0] errs, hold;
    logic found, lower_next;
    logic [6:0] zcnt;
    logic [12:0] words;
    logic [10:0] tmr;
  } eom_state_t;

  localparam eom_state_t ST_RST = '{rng_pwr: RANGE_PWR_RST,
    rsrc: RSRC_RST, lockmon: LOCKMON_RST, thresh: THRESH_RST,
    st: SC_IDLE, volt: AXIS_MID, default: '0};

  eom_state_t s;
  eom_state_t n;
  logic wr_stb, rd_req, push, pop, flush, fifo_rdy, fifo_val;
  logic dwell_done, err_now, counting;
  logic [7:0] req_addr, rd_ptr, wdata, rdata;
  logic [15:0] fifo_data, dwell_sq;

  // Sets up an opening measurement: phase sweep at mid voltage
  function automatic eom_state_t open_begin(eom_state_t x);
    eom_state_t y;
    y = x;
    y.st = SC_HSWEEP;
    y.phase = 6'h00;
    y.volt = AXIS_MID;
    y.acc = '0;
    y.errs = '0;
    y.found = 1'b0;
    y.zcnt = '0;
    return y;
  endfunction

  // Threshold nibble scaled to opening units
  function automatic logic [7:0] thr(logic [3:0] t);
    return {2'h0, t, 2'h0};
  endfunction

  eom_smb_slave u_bus (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .scl_in(scl_pin),
    .sda_in(sda_pin_in),
    .sda_out(sda_pin_out),
    .sda_oe(sda_pin_oe),
    .wr_stb(wr_stb),
    .rd_req(rd_req),
    .req_addr(req_addr),
    .wdata(wdata),
    .rd_ptr(rd_ptr),
    .rdata(rdata)
  );

  eom_fifo2 #(.W(16), .D(2)) u_buf (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .flush(flush),
    .in_valid(push),
    .in_ready(fifo_rdy),
    .in_data(s.errs),
    .out_valid(fifo_val),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  assign err_now = primary_bit ^ offset_bit;
  assign dwell_sq = 16'(s.dwell) * 16'(s.dwell);
  assign dwell_done = s.acc == {dwell_sq, DWELL_LOW};
  assign counting = s.st == SC_HSWEEP || s.st == SC_VSWEEP ||
                    s.st == SC_GRID;

  always_comb begin
    case (rd_ptr)
      UPPER_OFF: rdata = s.lower_next ? s.hold[7:0] : s.hold[15:8];
      LOWER_OFF: rdata = s.hold[7:0];
      HEO_OFF: rdata = s.horizontal_opening;
      VEO_OFF: rdata = s.vertical_opening;
      RANGE_PWR_OFF: rdata = s.rng_pwr;
      OVR_OFF: rdata = s.ovr;
      SCAN_OFF: rdata = {s.fast, 6'h00, s.start};
      DWELL_OFF: rdata = s.dwell;
      RSRC_OFF: rdata = s.rsrc;
      LOCKMON_OFF: rdata = s.lockmon;
      THRESH_OFF: rdata = s.thresh;
      CHSEL_OFF: rdata = s.chsel;
      default: rdata = 8'h00;
    endcase
  end

  always_comb begin
    logic zero;
    logic fd;
    logic [5:0] f;
    logic [5:0] l;
    logic [6:0] z;
    logic done_word;
    zero = s.errs == 16'h0000;
    fd = s.found | zero;
    f = s.found ? s.first : s.phase;
    l = zero ? s.phase : s.last;
    z = s.zcnt + {6'h00, zero};
    done_word = 1'b0;
    n = s;
    n.lock_lost = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    flush = 1'b0;
    if (counting && !dwell_done && sample_valid) begin
      n.acc = s.acc + 18'h00001;
      if (err_now && s.errs != 16'hffff) begin
        n.errs = s.errs + 16'h0001;
      end
    end
    case (s.st)
      SC_HSWEEP, SC_VSWEEP: begin
        if (dwell_done) begin
          n.acc = '0;
          n.errs = '0;
          n.found = fd;
          n.first = f;
          n.last = l;
          n.zcnt = z;
          if (s.st == SC_HSWEEP && s.phase == GRID_MAX) begin
            n.horizontal_opening = {1'b0, z};
            n.phase = fd ? 6'((7'(f) + 7'(l)) >> 1) : AXIS_MID;
            n.volt = 6'h00;
            n.found = 1'b0;
            n.zcnt = '0;
            n.st = SC_VSWEEP;
          end else if (s.st == SC_HSWEEP) begin
            n.phase = s.phase + 6'h01;
          end else if (s.volt == GRID_MAX) begin
            n.vertical_opening = {1'b0, z};
            n.volt = AXIS_MID;
            n.st = SC_IDLE;
            n.lm_run = 1'b0;
            n.start = s.fast & s.start;
            if (s.lm_run && (s.horizontal_opening < thr(s.thresh[7:4]) ||
                {1'b0, z} < thr(s.thresh[3:0]))) begin
              n.lock_lost = 1'b1;
            end
          end else begin
            n.volt = s.volt + 6'h01;
          end
        end
      end
      SC_GRID: begin
        if (dwell_done) begin
          n.st = SC_PUSH;
        end
      end
      SC_PUSH: begin
        push = 1'b1;
        if (fifo_rdy) begin
          n.acc = '0;
          n.errs = '0;
          n.st = SC_GRID;
          n.volt = s.volt + 6'h01;
          if (s.volt == GRID_MAX) begin
            n.phase = s.phase + 6'h01;
            if (s.phase == GRID_MAX) begin
              n.st = SC_IDLE;
            end
          end
        end
      end
      default: ;
    endcase
    // Periodic wake for lock validation while the bus leaves it alone
    if (s.lockmon[LOCKMON_BIT] && !s.fast && !s.start &&
        s.st == SC_IDLE) begin
      n.tmr = s.tmr + 11'h001;
      if (s.tmr == TMR_LAST) begin
        n.tmr = '0;
        n = open_begin(n);
        n.lm_run = 1'b1;
      end
    end else begin
      n.tmr = '0;
    end
    n.pwr_o = !s.rng_pwr[PWR_BIT] || s.st != SC_IDLE;
    n.range_o = s.rsrc[RSRC_BIT] ? cdr_range
                                 : s.rng_pwr[RANGE_LSB +: 2];
    if (rd_req && req_addr == UPPER_OFF) begin
      done_word = s.lower_next;
      n.lower_next = 1'b1;
    end else if (rd_req && req_addr == LOWER_OFF) begin
      done_word = s.lower_next;
    end
    if (done_word) begin
      n.lower_next = 1'b0;
      if (s.start && s.fast) begin
        n.words = s.words + 13'h0001;
        if (s.words == LAST_WORD) begin
          n.start = 1'b0;
        end else if (n.words >= DUMMY_WORDS && fifo_val) begin
          n.hold = fifo_data;
          pop = 1'b1;
        end
      end
    end
    if (wr_stb) begin
      case (req_addr)
        RANGE_PWR_OFF: n.rng_pwr = wdata;
        OVR_OFF: n.ovr = wdata;
        DWELL_OFF: n.dwell = wdata;
        RSRC_OFF: n.rsrc = wdata;
        LOCKMON_OFF: n.lockmon = wdata;
        THRESH_OFF: n.thresh = wdata;
        CHSEL_OFF: n.chsel = wdata;
        SCAN_OFF: begin
          n.fast = wdata[FAST_BIT];
          if (wdata[START_BIT] && !s.start && wdata[FAST_BIT]) begin
            n.start = 1'b1;
            n.st = SC_GRID;
            n.phase = 6'h00;
            n.volt = 6'h00;
            n.acc = '0;
            n.errs = '0;
            n.words = '0;
            n.hold = '0;
            n.lower_next = 1'b0;
            n.lm_run = 1'b0;
            flush = 1'b1;
          end else if (wdata[START_BIT] && !s.start) begin
            n = open_begin(n);
            n.start = 1'b1;
            n.lm_run = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s <= ST_RST;
    end else if (ce) begin
      s <= n;
    end
  end

  assign phase_offset = s.phase;
  assign volt_offset = s.volt;
  assign monitor_power = s.pwr_o;
  assign eom_range = s.range_o;
  assign lock_lost = s.lock_lost;

  chk_err_count: assert property (@(posedge clock)
    disable iff (!rstn || !ce)
    s.st == SC_GRID && !dwell_done && sample_valid && err_now &&
    s.errs != 16'hffff |=> s.errs == $past(s.errs) + 16'h0001)
    else $error("mismatch not counted");
  chk_err_saturate: assert property (@(posedge clock)
    disable iff (!rstn || !ce)
    s.st == SC_GRID && s.errs == 16'hffff && !dwell_done
    |=> s.errs == 16'hffff) else $error("error count wrapped");
  chk_raster_step: assert property (@(posedge clock)
    disable iff (!rstn || !ce)
    s.st == SC_PUSH && fifo_rdy && s.volt == GRID_MAX &&
    s.phase != GRID_MAX |=> s.volt == 6'h00 &&
    s.phase == $past(s.phase) + 6'h01 && s.st == SC_GRID)
    else $error("raster step out of order");
  chk_hsweep_mid: assert property (@(posedge clock)
    disable iff (!rstn) s.st == SC_HSWEEP |-> s.volt == AXIS_MID)
    else $error("phase sweep not at mid voltage");
  chk_lost_cause: assert property (@(posedge clock)
    disable iff (!rstn || !ce)
    lock_lost |-> $past(s.lm_run) && s.st == SC_IDLE && !s.lm_run)
    else $error("lock loss without monitor run");
  chk_power_on: assert property (@(posedge clock)
    disable iff (!rstn || !ce)
    !s.rng_pwr[PWR_BIT] |=> monitor_power)
    else $error("monitor not powered");
  chk_range_src: assert property (@(posedge clock)
    disable iff (!rstn || !ce)
    !s.rsrc[RSRC_BIT] |=> eom_range == $past(s.rng_pwr[RANGE_LSB +: 2]))
    else $error("range not taken from register");
  chk_fast_start: assert property (@(posedge clock)
    disable iff (!rstn || !ce)
    wr_stb && req_addr == SCAN_OFF && wdata[START_BIT] &&
    wdata[FAST_BIT] && !s.start
    |=> s.start && s.st == SC_GRID && s.words == 13'h0000)
    else $error("fast scan did not start");
  chk_start_done: assert property (@(posedge clock)
    disable iff (!rstn || !ce)
    rd_req && s.lower_next && s.start && s.fast &&
    s.words == LAST_WORD &&
    (req_addr == UPPER_OFF || req_addr == LOWER_OFF) |=> !s.start)
    else $error("start bit not cleared after readout");
  chk_upper_lower: assert property (@(posedge clock)
    disable iff (!rstn || !ce)
    rd_req && req_addr == UPPER_OFF && !s.lower_next
    |=> s.lower_next && (rd_ptr != UPPER_OFF || rdata == s.hold[7:0]))
    else $error("lower byte not presented after upper");
  chk_hold_wait: assert property (@(posedge clock)
    disable iff (!rstn || !ce)
    !rd_req && !wr_stb |=> $stable(s.hold))
    else $error("result replaced before both bytes read");
endmodule // eom_monitor

// *** rtl/eom_pkg.sv ***
// Register map, field positions, reset values and timing of the eye monitor
package eom_pkg;
  localparam logic [7:0] RANGE_PWR_OFF = 8'h11;
  localparam logic [7:0] OVR_OFF = 8'h22;
  localparam logic [7:0] SCAN_OFF = 8'h24;
  localparam logic [7:0] UPPER_OFF = 8'h25;
  localparam logic [7:0] LOWER_OFF = 8'h26;
  localparam logic [7:0] HEO_OFF = 8'h27;
  localparam logic [7:0] VEO_OFF = 8'h28;
  localparam logic [7:0] DWELL_OFF = 8'h2a;
  localparam logic [7:0] RSRC_OFF = 8'h2c;
  localparam logic [7:0] LOCKMON_OFF = 8'h3e;
  localparam logic [7:0] THRESH_OFF = 8'h6a;
  localparam logic [7:0] CHSEL_OFF = 8'hff;
  localparam int PWR_BIT = 5;
  localparam int RANGE_LSB = 6;
  localparam int FAST_BIT = 7;
  localparam int START_BIT = 0;
  localparam int RSRC_BIT = 6;
  localparam int LOCKMON_BIT = 7;
  localparam logic [7:0] RANGE_PWR_RST = 8'h20;
  localparam logic [7:0] RSRC_RST = 8'h40;
  localparam logic [7:0] LOCKMON_RST = 8'h80;
  localparam logic [7:0] THRESH_RST = 8'h44;
  // Last index of the 64-step phase and voltage axes
  localparam logic [5:0] GRID_MAX = 6'h3f;
  localparam logic [5:0] AXIS_MID = 6'h20;
  // Two junk words lead each readout; 4096 results follow
  localparam logic [12:0] DUMMY_WORDS = 13'h0002;
  localparam logic [12:0] LAST_WORD = 13'h1001;
  // Low bits of the dwell target, below dwell squared
  // Dwell 0 takes 3 samples per point, dwell 255 about 2^18
  localparam logic [1:0] DWELL_LOW = 2'h3;
  localparam int CLK_MHZ = 100;
  localparam int LOCKMON_PERIOD_US = 20;
  localparam int LOCKMON_CYC = LOCKMON_PERIOD_US * CLK_MHZ;
  localparam logic [10:0] TMR_LAST = 11'(LOCKMON_CYC - 1);
  // Bus address of the device; value is arbitrary
  localparam logic [6:0] SMB_DEV_ADDR = 7'h18;
  typedef enum logic [2:0] {
    SC_IDLE, SC_HSWEEP, SC_VSWEEP, SC_GRID, SC_PUSH
  } eom_scan_t;
  typedef enum logic [2:0] {
    SL_IDLE, SL_ADDR, SL_AACK, SL_WBYTE, SL_WACK, SL_RBYTE, SL_RACK
  } eom_sl_t;
endpackage

// *** rtl/eom_fifo2.sv ***
// Two-entry result buffer between scan engine and readout
module eom_fifo2 #(
  parameter int W = 16,
  parameter int D = 2
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  import eom_pkg::*;
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } eom_fifo_state_t;
  eom_fifo_state_t s;
  eom_fifo_state_t n;
  logic wr;
  logic rd;
  assign in_ready = s.cnt != CW'(D);
  assign out_valid = s.cnt != '0;
  assign out_data = s.mem[s.rp];
  assign wr = in_valid && in_ready;
  assign rd = out_valid && out_ready;
  always_comb begin
    n = s;
    if (wr) begin
      n.mem[s.wp] = in_data;
      n.wp = (s.wp == AW'(D - 1)) ? '0 : s.wp + AW'(1);
    end
    if (rd) begin
      n.rp = (s.rp == AW'(D - 1)) ? '0 : s.rp + AW'(1);
    end
    n.cnt = s.cnt + CW'(wr) - CW'(rd);
    if (flush) begin
      n = '0;
    end
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end
  chk_fifo_bounds: assert property (@(posedge clock) disable iff (!rstn)
    s.cnt <= CW'(D)) else $error("buffer count beyond depth");
endmodule // eom_fifo2

// *** rtl/eom_smb_slave.sv ***
// Two-wire management bus slave with register pointer
module eom_smb_slave (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic wr_stb,
  output logic rd_req,
  output logic [7:0] req_addr,
  output logic [7:0] wdata,
  output logic [7:0] rd_ptr,
  input wire logic [7:0] rdata
);
  import eom_pkg::*;
  typedef struct packed {
    logic scl1, scl2, scl3, sda1, sda2, sda3;
    eom_sl_t st;
    logic [3:0] bcnt;
    logic [7:0] sh, ptr, a, wd;
    logic first, rd, nack, oe, wr, rq;
  } eom_sl_state_t;
  localparam eom_sl_state_t SL_RST = '{st: SL_IDLE, scl1: 1'b1,
    scl2: 1'b1, scl3: 1'b1, sda1: 1'b1, sda2: 1'b1, sda3: 1'b1,
    default: '0};
  eom_sl_state_t s;
  eom_sl_state_t n;
  logic rise, fall, start, stop;

  // Count result register keeps the pointer for burst streaming
  function automatic logic [7:0] adv(logic [7:0] p);
    return (p == UPPER_OFF) ? p : p + 8'h01;
  endfunction

  function automatic eom_sl_state_t load(eom_sl_state_t x,
                                         logic [7:0] d);
    eom_sl_state_t y;
    y = x;
    y.rq = 1'b1;
    y.a = x.ptr;
    y.sh = d;
    y.oe = !d[7];
    y.bcnt = 4'h0;
    y.ptr = adv(x.ptr);
    y.st = SL_RBYTE;
    return y;
  endfunction

  assign rise = s.scl2 && !s.scl3;
  assign fall = !s.scl2 && s.scl3;
  assign start = s.scl2 && s.scl3 && s.sda3 && !s.sda2;
  assign stop = s.scl2 && s.scl3 && !s.sda3 && s.sda2;

  always_comb begin
    n = s;
    n.scl1 = scl_in;
    n.scl2 = s.scl1;
    n.scl3 = s.scl2;
    n.sda1 = sda_in;
    n.sda2 = s.sda1;
    n.sda3 = s.sda2;
    n.wr = 1'b0;
    n.rq = 1'b0;
    if (start) begin
      n.st = SL_ADDR;
      n.bcnt = 4'h0;
      n.oe = 1'b0;
      n.first = 1'b1;
    end else if (stop) begin
      n.st = SL_IDLE;
      n.oe = 1'b0;
    end else begin
      case (s.st)
        SL_IDLE: ;
        SL_ADDR, SL_WBYTE: begin
          if (rise) begin
            n.sh = {s.sh[6:0], s.sda2};
            n.bcnt = s.bcnt + 4'h1;
          end else if (fall && s.bcnt == 4'h8) begin
            n.bcnt = 4'h0;
            n.oe = 1'b1;
            if (s.st == SL_ADDR) begin
              n.rd = s.sh[0];
              n.st = (s.sh[7:1] == SMB_DEV_ADDR) ? SL_AACK : SL_IDLE;
              n.oe = s.sh[7:1] == SMB_DEV_ADDR;
            end else begin
              n.st = SL_WACK;
              n.first = 1'b0;
              n.wr = !s.first;
              n.a = s.ptr;
              n.wd = s.sh;
              n.ptr = s.first ? s.sh : adv(s.ptr);
            end
          end
        end
        SL_AACK: begin
          if (fall && s.rd) begin
            n = load(n, rdata);
          end else if (fall) begin
            n.oe = 1'b0;
            n.st = SL_WBYTE;
          end
        end
        SL_WACK: begin
          if (fall) begin
            n.oe = 1'b0;
            n.st = SL_WBYTE;
          end
        end
        SL_RBYTE: begin
          if (fall && s.bcnt == 4'h7) begin
            n.oe = 1'b0;
            n.st = SL_RACK;
          end else if (fall) begin
            n.sh = {s.sh[6:0], 1'b0};
            n.oe = !s.sh[6];
            n.bcnt = s.bcnt + 4'h1;
          end
        end
        SL_RACK: begin
          if (rise) begin
            n.nack = s.sda2;
          end else if (fall && !s.nack) begin
            n = load(n, rdata);
          end else if (fall) begin
            n.st = SL_IDLE;
          end
        end
        default: n.st = SL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s <= SL_RST;
    end else if (ce) begin
      s <= n;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = s.oe;
  assign wr_stb = s.wr;
  assign rd_req = s.rq;
  assign req_addr = s.a;
  assign wdata = s.wd;
  assign rd_ptr = s.ptr;

  chk_burst_ptr_hold: assert property (@(posedge clock)
    disable iff (!rstn) rd_req && req_addr == UPPER_OFF |-> rd_ptr == UPPER_OFF)
    else $error("pointer left the count register in a burst");
  chk_idle_release: assert property (@(posedge clock) disable iff (!rstn)
    s.st == SL_IDLE |-> !s.oe) else $error("data line driven while idle");
endmodule // eom_smb_slave

// *** verification/eom_host_model.sv ***
// Bus controller model: open-drain bits, bytes and register transfers
module eom_host_model
  import eom_pkg::*;
(
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx [0:7];
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q();
    repeat (2) @(negedge clock);
  endtask
  // Data moves mid-low; the wire is sampled as the high phase ends
  task automatic bit_io(input logic b, output logic r);
    q();
    sda_low = ~b;
    q();
    scl = 1'b1;
    q();
    q();
    r = sda;
    scl = 1'b0;
  endtask
  task automatic start_c();
    q();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
  endtask
  task automatic stop_c();
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask
  task automatic tx(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
  endtask
  task automatic rx_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    start_c();
    tx({SMB_DEV_ADDR, 1'b0});
    tx(a);
    tx(d);
    stop_c();
  endtask
  // Pointer write, repeated start, then n bytes; the last is not acked
  task automatic read_regs(input logic [7:0] a, input int n);
    start_c();
    tx({SMB_DEV_ADDR, 1'b0});
    tx(a);
    start_c();
    tx({SMB_DEV_ADDR, 1'b1});
    for (int i = 0; i < n; i++) rx_byte(i == n - 1, rx[i]);
    stop_c();
  endtask
endmodule // eom_host_model

// *** verification/testbench.sv ***
// Self-checking bench for the eye monitor readout
module testbench;
  import eom_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rstn, primary_bit, offset_bit, scl, host_low, err_mode;
  logic sda_pin_out, sda_pin_oe, monitor_power, lock_lost;
  logic [1:0] cdr_range, eom_range;
  logic [5:0] phase_offset, volt_offset;
  wire logic sda_line;
  int fail_count, checks;
  // Open-drain data wire with pull-up
  assign sda_line = ~((sda_pin_oe & ~sda_pin_out) | host_low);
  eom_monitor dut (
    .clock(clock),
    .rstn(rstn),
    .ce(1'b1),
    .scl_pin(scl),
    .sda_pin_in(sda_line),
    .sda_pin_out(sda_pin_out),
    .sda_pin_oe(sda_pin_oe),
    .sample_valid(1'b1),
    .primary_bit(primary_bit),
    .offset_bit(offset_bit),
    .cdr_range(cdr_range),
    .phase_offset(phase_offset),
    .volt_offset(volt_offset),
    .monitor_power(monitor_power),
    .eom_range(eom_range),
    .lock_lost(lock_lost)
  );
  eom_host_model u_host (
    .clock(clock),
    .sda(sda_line),
    .scl(scl),
    .sda_low(host_low)
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Eye open at phase 16..47, voltage 24..39; scan mode errs on even volts
  function automatic logic eye_err(input logic [5:0] p, input logic [5:0] v);
    if (err_mode) return ~v[0];
    return p < 6'h10 || p > 6'h2f || v < 6'h18 || v > 6'h27;
  endfunction
  always @(negedge clock) begin
    primary_bit <= ~primary_bit;
    offset_bit <= ~primary_bit ^ eye_err(phase_offset, volt_offset);
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic check(input string n, input logic [7:0] got,
                       input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic close_out();
    $display("fail_count %0d checks %0d", fail_count, checks);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    u_host.read_regs(a, 1);
    check($sformatf("reg %h", a), u_host.rx[0], e);
  endtask
  task automatic burst(input int n, input logic [63:0] e);
    u_host.read_regs(UPPER_OFF, n);
    for (int i = 0; i < n; i++)
      check("burst byte", u_host.rx[i], e[63-8*i -: 8]);
  endtask
  task automatic t_opening();
    int i;
    u_host.write_reg(THRESH_OFF, 8'h90);
    for (i = 0; i < 20000 && lock_lost !== 1'b1; i++) cyc(1);
    check("loss seen", {7'h0, lock_lost}, 8'h01);
    if (lock_lost !== 1'b1)
      close_out();
    check("phase centre", {2'h0, phase_offset}, 8'h1f);
    check("volt mid", {2'h0, volt_offset}, {2'h0, AXIS_MID});
    cyc(1);
    check("loss pulse", {7'h0, lock_lost}, 8'h00);
    u_host.write_reg(LOCKMON_OFF, 8'h00);
    rd_chk(HEO_OFF, 8'h20);
    rd_chk(VEO_OFF, 8'h10);
    u_host.write_reg(HEO_OFF, 8'hff);
    rd_chk(HEO_OFF, 8'h20);
  endtask
  task automatic t_reset();
    logic [47:0] offs, vals;
    rstn = 1'b0;
    cyc(3);
    rstn = 1'b1;
    cyc(4);
    check("power idle", {7'h0, monitor_power}, 8'h00);
    check("range src", {6'h0, eom_range}, {6'h0, cdr_range});
    rd_chk(LOCKMON_OFF, LOCKMON_RST);
    u_host.write_reg(LOCKMON_OFF, 8'h00);
    offs = {RANGE_PWR_OFF, RSRC_OFF, THRESH_OFF, SCAN_OFF, OVR_OFF, 8'h50};
    vals = {RANGE_PWR_RST, RSRC_RST, THRESH_RST, 24'h000000};
    for (int i = 0; i < 6; i++)
      rd_chk(offs[47-8*i -: 8], vals[47-8*i -: 8]);
  endtask
  task automatic t_range();
    u_host.write_reg(RSRC_OFF, 8'h00);
    for (int r = 0; r < 4; r++) begin
      u_host.write_reg(RANGE_PWR_OFF, {r[1:0], 6'h00});
      cyc(2);
      check("range", {6'h0, eom_range}, {6'h0, r[1:0]});
      check("power on", {7'h0, monitor_power}, 8'h01);
    end
  endtask
  task automatic t_scan();
    err_mode = 1'b1;
    u_host.write_reg(CHSEL_OFF, 8'h00);
    u_host.write_reg(RANGE_PWR_OFF, 8'h00);
    u_host.write_reg(OVR_OFF, 8'h00);
    // Dwell 0x10: 0x10 squared, shifted by two, plus three = 0x403
    u_host.write_reg(DWELL_OFF, 8'h10);
    u_host.write_reg(SCAN_OFF, 8'h81);
    cyc(4000);
    burst(8, 64'h0000_0000_0403_0000);
    cyc(2500);
    burst(4, 64'h0403_0000_0000_0000);
    cyc(2500);
    rd_chk(UPPER_OFF, 8'h04);
    rd_chk(LOWER_OFF, 8'h03);
    rd_chk(SCAN_OFF, 8'h81);
    u_host.write_reg(SCAN_OFF, 8'h00);
    u_host.write_reg(RANGE_PWR_OFF, 8'h20);
    u_host.write_reg(LOCKMON_OFF, 8'h80);
  endtask
  initial begin
    rstn = 1'b0;
    primary_bit = 1'b0;
    offset_bit = 1'b0;
    cdr_range = 2'b10;
    err_mode = 1'b0;
    fail_count = 0;
    checks = 0;
    cyc(3);
    rstn = 1'b1;
    cyc(4);
    t_opening();
    t_reset();
    t_range();
    t_scan();
    close_out();
  end
endmodule // testbench
